// ===== verilog/eeprom_page_host.sv
// host controller: unlocked page writes, status polling and reads of a parallel eeprom
`timescale 1ns/10ps
`default_nettype none
module eeprom_page_host
    import eeprom_host_pkg::*;
#(
    parameter int                PROG_CYC = WC_CYC,
    parameter logic [ADDR_W-1:0] UA0      = 13'h0001,
    parameter logic [ADDR_W-1:0] UA1      = 13'h0002,
    parameter logic [ADDR_W-1:0] UA2      = 13'h0003,
    parameter logic [DATA_W-1:0] UD0      = 8'h01,
    parameter logic [DATA_W-1:0] UD1      = 8'h02,
    parameter logic [DATA_W-1:0] UD2      = 8'h03
) (
    input  wire logic                         clock,
    input  wire logic                         arst_n,
    input  wire logic                         enable,
    input  wire logic                         load_valid,
    input  wire logic [PAGE_LSB-1:0]          load_offset,
    input  wire logic [DATA_W-1:0]            load_data,
    output logic                              load_ready,
    input  wire logic                         wr_req,
    input  wire logic [ADDR_W-PAGE_LSB-1:0]   wr_page,
    output logic                              wr_done,
    output logic                              wr_error,
    input  wire logic                         rd_req,
    input  wire logic [ADDR_W-1:0]            rd_addr,
    output logic                              rd_valid,
    output logic      [DATA_W-1:0]            rd_data,
    output logic                              busy,
    output logic                              mem_ce_n,
    output logic                              mem_oe_n,
    output logic                              mem_we_n,
    output logic      [ADDR_W-1:0]            mem_addr,
    output logic      [DATA_W-1:0]            mem_dq_out,
    output logic                              mem_dq_oe,
    input  wire logic [DATA_W-1:0]            mem_dq_in
);
    // ==========================================================
    // elaboration checks
    // timer runs on to the end of a poll read after expiry, so leave room for it
    localparam int PW = $clog2(PROG_CYC + RD_CYC + 1);
    localparam int CW = $clog2(PAGE_BYTES + UNLOCK_STEPS + 1);
    if (PROG_CYC < 1 || PAGE_BYTES != (1 << PAGE_LSB) || RD_CYC >= (1 << PHASE_W)) begin : g_bad
        $error("eeprom_page_host: unsupported parameter values");
    end

    // ==========================================================
    // state
    state_t                        st;
    logic [CW-1:0]                 cnt;
    logic [CW-1:0]                 seq;
    logic [ADDR_W-PAGE_LSB-1:0]    page;
    logic [PHASE_W-1:0]            ph;
    logic [PW-1:0]                 prog_tmr;
    logic [ADDR_W-1:0]             last_addr;
    logic [DATA_W-1:0]             last_data;
    logic                          prev_tog;
    logic                          have_prev;
    logic [DATA_W-1:0]             dq_s1;
    logic [DATA_W-1:0]             dq_s2;
    logic [PAGE_LSB+DATA_W-1:0]    buf_rdata;

    // ==========================================================
    // decoding
    wire              load_take  = load_valid && load_ready;
    wire              in_unlock  = seq < CW'(UNLOCK_STEPS);
    wire [CW-1:0]     buf_pos    = seq - CW'(UNLOCK_STEPS);
    wire [CW-1:0]     total      = cnt + CW'(UNLOCK_STEPS);
    wire              all_sent   = seq == total;
    wire              pulse_end  = ph == PHASE_W'(WP_CYC - 1);
    wire              gap_end    = ph == PHASE_W'(WPH_CYC - 1);
    wire              rd_end     = ph == PHASE_W'(RD_CYC - 1);
    wire              ohp_end    = ph == PHASE_W'(OEHP_CYC - 1);
    // at or past: expiry may land inside a poll read and must not be missed
    wire              timed_out  = prog_tmr >= PW'(PROG_CYC);
    wire [ADDR_W-1:0] ua_sel     = (seq == CW'(0)) ? UA0 : (seq == CW'(1)) ? UA1 : UA2;
    wire [DATA_W-1:0] ud_sel     = (seq == CW'(0)) ? UD0 : (seq == CW'(1)) ? UD1 : UD2;
    // page bits from one latched value
    wire [ADDR_W-1:0] step_addr  = in_unlock ? ua_sel : {page, buf_rdata[PAGE_LSB+DATA_W-1:DATA_W]};
    wire [DATA_W-1:0] step_data  = in_unlock ? ud_sel : buf_rdata[DATA_W-1:0];
    // poll bit shows true data, toggle bit has settled
    wire              poll_ok    = dq_s2[POLL_STATUS_BIT] == last_data[POLL_STATUS_BIT];
    wire              tog_ok     = have_prev && (dq_s2[TOGGLE_STATUS_BIT] == prev_tog);
    wire              prog_done  = poll_ok && tog_ok;
    wire              idle_next  = (st == ST_IDLE && !wr_req && !rd_req)
                                   || (st == ST_POLL_RD && rd_end && (prog_done || timed_out))
                                   || (st == ST_POLL_GAP && timed_out)
                                   || (st == ST_READ && rd_end);
    wire [CW-1:0]     next_cnt   = load_take ? cnt + CW'(1) : cnt;

    page_buffer #(
        .WIDTH (PAGE_LSB + DATA_W),
        .DEPTH (PAGE_BYTES)
    ) u_buf (
        .clock  (clock),
        .arst_n (arst_n),
        .enable (enable),
        .we     (load_take),
        .waddr  (cnt[PAGE_LSB-1:0]),
        .wdata  ({load_offset, load_data}),
        .raddr  (buf_pos[PAGE_LSB-1:0]),
        .rdata  (buf_rdata)
    );

    // ==========================================================
    // pin input synchroniser
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else if (enable) begin
            dq_s1 <= mem_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_IDLE;
            cnt <= '0;
            seq <= '0;
            page <= '0;
            ph <= '0;
            prog_tmr <= '0;
            last_addr <= '0;
            last_data <= '0;
            prev_tog <= 1'b0;
            have_prev <= 1'b0;
            load_ready <= 1'b0;
            wr_done <= 1'b0;
            wr_error <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            busy <= 1'b0;
            mem_ce_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_addr <= '0;
            mem_dq_out <= '0;
            mem_dq_oe <= 1'b0;
        end else if (enable) begin
            wr_done <= 1'b0;
            wr_error <= 1'b0;
            rd_valid <= 1'b0;
            ph <= ph + PHASE_W'(1);
            cnt <= next_cnt;
            load_ready <= idle_next && (next_cnt != CW'(PAGE_BYTES));
            busy <= !idle_next;
            unique case (st)
                ST_IDLE: begin
                    ph <= '0;
                    // a write always restarts at the unlock
                    if (wr_req && cnt != '0) begin
                        st <= ST_GAP;
                        seq <= '0;
                        page <= wr_page;
                        mem_oe_n <= 1'b0;
                    end else if (rd_req) begin
                        st <= ST_READ;
                        mem_addr <= rd_addr;
                        mem_ce_n <= 1'b0;
                        mem_oe_n <= 1'b0;
                    end
                end
                ST_GAP: begin
                    if (all_sent) begin
                        st <= ST_POLL_RD;
                        ph <= '0;
                        prog_tmr <= '0;
                        have_prev <= 1'b0;
                        mem_addr <= last_addr;
                        mem_ce_n <= 1'b0;
                    end else if (gap_end) begin
                        // strobes low with output enable high
                        st <= ST_PULSE;
                        ph <= '0;
                        mem_addr <= step_addr;
                        mem_dq_out <= step_data;
                        mem_dq_oe <= 1'b1;
                        mem_oe_n <= 1'b1;
                        mem_ce_n <= 1'b0;
                        mem_we_n <= 1'b0;
                    end
                end
                ST_PULSE: begin
                    if (pulse_end) begin
                        // short fixed gap keeps the byte load window
                        st <= ST_GAP;
                        ph <= '0;
                        seq <= seq + CW'(1);
                        last_addr <= mem_addr;
                        last_data <= mem_dq_out;
                        mem_dq_oe <= 1'b0;
                        mem_ce_n <= 1'b1;
                        mem_we_n <= 1'b1;
                        mem_oe_n <= 1'b0;
                    end
                end
                ST_POLL_RD: begin
                    prog_tmr <= prog_tmr + PW'(1);
                    if (rd_end) begin
                        ph <= '0;
                        prev_tog <= dq_s2[TOGGLE_STATUS_BIT];
                        have_prev <= 1'b1;
                        mem_ce_n <= 1'b1;
                        mem_oe_n <= 1'b1;
                        if (prog_done || timed_out) begin
                            st <= ST_IDLE;
                            cnt <= '0;
                            wr_done <= prog_done;
                            wr_error <= !prog_done;
                        end else begin
                            st <= ST_POLL_GAP;
                        end
                    end
                end
                ST_POLL_GAP: begin
                    prog_tmr <= prog_tmr + PW'(1);
                    if (timed_out) begin
                        st <= ST_IDLE;
                        cnt <= '0;
                        wr_error <= 1'b1;
                    end else if (ohp_end) begin
                        st <= ST_POLL_RD;
                        ph <= '0;
                        mem_ce_n <= 1'b0;
                        mem_oe_n <= 1'b0;
                    end
                end
                ST_READ: begin
                    if (rd_end) begin
                        st <= ST_IDLE;
                        rd_data <= dq_s2;
                        rd_valid <= 1'b1;
                        mem_ce_n <= 1'b1;
                        mem_oe_n <= 1'b1;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                    mem_ce_n <= 1'b1;
                    mem_oe_n <= 1'b1;
                    mem_we_n <= 1'b1;
                    mem_dq_oe <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // checks; helper counts write strobes since leaving idle
    localparam int BLOAD_MAX = 1000;
    logic          we_prev;
    logic [CW-1:0] pulse_num;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            we_prev <= 1'b1;
            pulse_num <= '0;
        end else begin
            we_prev <= mem_we_n;
            if (st == ST_IDLE) begin
                pulse_num <= '0;
            end else if (we_prev && !mem_we_n) begin
                pulse_num <= pulse_num + CW'(1);
            end
        end
    end

    property p_unlock_first;
        @(posedge clock) disable iff (!arst_n)
        $fell(mem_we_n) && pulse_num == '0 |-> mem_addr == UA0 && mem_dq_out == UD0;
    endproperty
    a_unlock_first: assert property (p_unlock_first) else $error("first strobe not unlock");

    property p_unlock_rest;
        @(posedge clock) disable iff (!arst_n)
        $fell(mem_we_n) && pulse_num != '0 && pulse_num < CW'(UNLOCK_STEPS)
        |-> mem_addr == ((pulse_num == CW'(1)) ? UA1 : UA2);
    endproperty
    a_unlock_rest: assert property (p_unlock_rest) else $error("unlock address wrong");

    property p_same_page;
        @(posedge clock) disable iff (!arst_n)
        $fell(mem_we_n) && pulse_num >= CW'(UNLOCK_STEPS) |-> mem_addr[ADDR_W-1:PAGE_LSB] == page;
    endproperty
    a_same_page: assert property (p_same_page) else $error("page bits changed in load");

    property p_byte_count;
        @(posedge clock) disable iff (!arst_n)
        (st == ST_GAP) ##1 (st == ST_POLL_RD) |-> pulse_num == total && cnt != '0;
    endproperty
    a_byte_count: assert property (p_byte_count) else $error("loaded byte count wrong");

    property p_load_window;
        @(posedge clock) disable iff (!arst_n)
        $rose(mem_we_n) && enable && !all_sent |-> ##[1:BLOAD_MAX] $fell(mem_we_n);
    endproperty
    a_load_window: assert property (p_load_window) else $error("next byte too late");

    property p_oe_in_write;
        @(posedge clock) disable iff (!arst_n)
        (st == ST_PULSE || st == ST_GAP) |-> mem_oe_n == (!mem_we_n && !mem_ce_n);
    endproperty
    a_oe_in_write: assert property (p_oe_in_write) else $error("oe high outside strobe");

    property p_no_contention;
        @(posedge clock) disable iff (!arst_n)
        mem_dq_oe |-> mem_oe_n && !mem_we_n;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("host drives data in read");

    property p_prog_bound;
        @(posedge clock) disable iff (!arst_n)
        $fell(busy) && ($past(st) == ST_POLL_RD || $past(st) == ST_POLL_GAP)
        |-> prog_tmr <= PW'(PROG_CYC + RD_CYC) && (wr_done ^ wr_error);
    endproperty
    a_prog_bound: assert property (p_prog_bound) else $error("write end not reported");
endmodule
`default_nettype wire

// ===== verilog/eeprom_host_pkg.sv
// constants, timing counts and state codes for the page-write host controller
// What this block does
// - every byte or page write starts with the three-byte unlock sequence
// - one to 64 bytes load after unlock and program in one period
// - each next byte strobe follows the previous within 100 microseconds
// - page select bits stay identical at every falling write strobe of the load
// - the three unlock bytes carry the full fixed unlock addresses
// - output enable is high during a write only while both strobes are low
package eeprom_host_pkg;

    // ==========================================================
    // bus shape
    localparam int ADDR_W       = 13;
    localparam int DATA_W       = 8;
    localparam int PAGE_LSB     = 6;
    localparam int PAGE_BYTES   = 64;
    localparam int UNLOCK_STEPS = 3;
    localparam int POLL_STATUS_BIT   = 7;
    localparam int TOGGLE_STATUS_BIT = 6;

    // ==========================================================
    // timing, figures in their own units
    localparam int CLK_MHZ   = 25;
    localparam int T_WP_NS   = 200;
    localparam int T_WPH_NS  = 100;
    localparam int T_ACC_NS  = 200;
    localparam int T_OEHP_NS = 150;
    localparam int T_BLC_US  = 100;
    localparam int T_WC_MS   = 10;

    function automatic int ns_to_cyc_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WP_CYC    = ns_to_cyc_up(T_WP_NS);
    localparam int WPH_CYC   = ns_to_cyc_up(T_WPH_NS);
    localparam int ACC_CYC   = ns_to_cyc_up(T_ACC_NS);
    localparam int OEHP_CYC  = ns_to_cyc_up(T_OEHP_NS);
    localparam int SYNC_CYC  = 2;
    localparam int RD_CYC    = ACC_CYC + SYNC_CYC + 1;
    localparam int BLC_CYC   = T_BLC_US * CLK_MHZ;
    localparam int WC_CYC    = T_WC_MS * 1000 * CLK_MHZ;
    localparam int PHASE_W   = 4;

    // ==========================================================
    // controller states, gray along idle-pulse-gap-poll
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_PULSE    = 3'h1,
        ST_GAP      = 3'h3,
        ST_POLL_RD  = 3'h2,
        ST_POLL_GAP = 3'h6,
        ST_READ     = 3'h4
    } state_t;

endpackage

// ===== verilog/page_buffer.sv
// small page buffer memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module page_buffer #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 64
) (
    input  wire logic                     clock,
    input  wire logic                     arst_n,
    input  wire logic                     enable,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);
    if (WIDTH < 1 || DEPTH < 2) begin : g_bad
        $error("page_buffer: width or depth too small");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (enable && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (enable) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ===== verif/eeprom_dev_model.sv
// behavioural parallel eeprom: unlock, page load, timed programming, status bits
`timescale 1ns/10ps
`default_nettype none
module eeprom_dev_model
    import eeprom_host_pkg::*;
#(
    parameter logic [ADDR_W-1:0] UA0     = 13'h0001,
    parameter logic [ADDR_W-1:0] UA1     = 13'h0002,
    parameter logic [ADDR_W-1:0] UA2     = 13'h0003,
    parameter logic [DATA_W-1:0] UD0     = 8'h01,
    parameter logic [DATA_W-1:0] UD1     = 8'h02,
    parameter logic [DATA_W-1:0] UD2     = 8'h03,
    parameter int                BLC_LEN = 20
) (
    input  wire logic              clock,
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic              host_oe,
    input  wire logic [9:0]        prog_len,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   prog_busy,
    output logic      [15:0]       viol
);
    // ==========================================================
    // storage and load state
    logic [DATA_W-1:0]     mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0]     pend [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pend_v = '0;
    logic [ADDR_W-1:0]     wr_addr, page_addr;
    logic [DATA_W-1:0]     wr_data, last_data = 8'h00, last_dq = 8'h00;
    logic [1:0]            step = 2'h0;
    logic                  wr_prev = 0, rd_prev = 0, tog = 0, loaded = 0;
    int                    blc = 0, pcnt = 0;

    initial begin
        prog_busy = 0;
        viol = 16'h0;
        for (int a = 0; a < (1 << ADDR_W); a++) begin
            mem[a] = a[7:0] ^ a[12:5];
        end
    end

    function automatic logic [20:0] ucode(input logic [1:0] s);
        return (s == 2'h0) ? {UA0, UD0} : (s == 2'h1) ? {UA1, UD1} : {UA2, UD2};
    endfunction

    wire wr_on = !ce_n && !we_n && oe_n;
    wire rd_on = !ce_n && !oe_n && we_n;
    wire [DATA_W-1:0] status = {~last_data[POLL_STATUS_BIT], tog, last_data[5:0]};
    // drive only when read enabled; a released bus shows the inverse
    assign dq_out = rd_on ? (prog_busy ? status : mem[addr]) : ~last_dq;

    // ==========================================================
    // bus sequencing
    always @(posedge clock) begin
        wr_prev <= wr_on;
        rd_prev <= rd_on;
        if (rd_on) last_dq <= dq_out;
        if (wr_on) wr_data <= dq_in;
        if (wr_on && !wr_prev) wr_addr <= addr;
        if (rd_on && !rd_prev && prog_busy) tog <= ~tog;
        if (rd_on && host_oe) viol <= viol + 16'h1;
        // oe high only inside a strobe
        if ((step == 2'h1 || step == 2'h2) && oe_n && !(!ce_n && !we_n)) viol <= viol + 16'h1;
        if (!wr_on && wr_prev) begin
            blc <= 0;
            if (prog_busy) begin
                viol <= viol + 16'h1;
            end else if (step != 2'h3) begin
                if ({wr_addr, wr_data} == ucode(step)) begin
                    step <= step + 2'h1;
                end else begin
                    viol <= viol + 16'h1;
                    step <= 2'h0;
                end
            end else begin
                if (loaded && wr_addr[ADDR_W-1:PAGE_LSB] != page_addr[ADDR_W-1:PAGE_LSB])
                    viol <= viol + 16'h1;
                page_addr <= wr_addr;
                loaded <= 1;
                pend[wr_addr[PAGE_LSB-1:0]] <= wr_data;
                pend_v[wr_addr[PAGE_LSB-1:0]] <= 1;
                last_data <= wr_data;
            end
        end else if (step != 2'h0 && !prog_busy) begin
            blc <= blc + 1;
            // window close or poll read starts one period
            if (blc == BLC_LEN || (rd_on && !rd_prev)) begin
                step <= 2'h0;
                if (step == 2'h3 && loaded) begin
                    prog_busy <= 1;
                    pcnt <= 0;
                end else begin
                    viol <= viol + 16'h1;
                end
            end
        end
        if (prog_busy) begin
            pcnt <= pcnt + 1;
            if (pcnt == int'(prog_len)) begin
                prog_busy <= 0;
                loaded <= 0;
                pend_v <= '0;
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (pend_v[i]) mem[{page_addr[ADDR_W-1:PAGE_LSB], 6'(i)}] <= pend[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench: random page writes, reads, stalls and refusals
`timescale 1ns/10ps
`default_nettype none
module tb;
    import eeprom_host_pkg::*;
    logic              clock, arst_n, enable, load_valid, wr_req, rd_req;
    logic              load_ready, wr_done, wr_error, rd_valid, busy, dev_busy;
    logic              mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe;
    logic [5:0]        load_offset;
    logic [6:0]        wr_page;
    logic [7:0]        load_data, rd_data, mem_dq_out, dev_dq;
    logic [12:0]       rd_addr, mem_addr;
    logic [9:0]        prog_len;
    logic [15:0]       viol;
    logic [7:0]        shadow [0:8191];
    int                miscompares = 0, cmp_count = 0;
    wire  [7:0]        mem_dq_in = mem_dq_oe ? mem_dq_out : dev_dq;

    eeprom_page_host #(.PROG_CYC(200)) dut (.clock(clock), .arst_n(arst_n), .enable(enable),
        .load_valid(load_valid), .load_offset(load_offset), .load_data(load_data),
        .load_ready(load_ready), .wr_req(wr_req), .wr_page(wr_page), .wr_done(wr_done),
        .wr_error(wr_error), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .busy(busy), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
        .mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
    eeprom_dev_model dev (.clock(clock), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
        .addr(mem_addr), .dq_in(mem_dq_out), .host_oe(mem_dq_oe), .prog_len(prog_len),
        .dq_out(dev_dq), .prog_busy(dev_busy), .viol(viol));

    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end

    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic timeout(input string what);
        miscompares++;
        $display("wrong value %s expected handshake seen none", what);
        end_sim();
    endtask

    task automatic push(input logic [5:0] off, input logic [7:0] d);
        int k;
        load_valid <= 1;
        load_offset <= off;
        load_data <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            if (load_ready === 1'b1) break;
        end
        if (k == 20) timeout("load_ready");
    endtask

    // stall drops the clock enable for that many edges in mid-read
    task automatic rd(input logic [12:0] a, input int stall = 0);
        int k;
        rd_req <= 1;
        rd_addr <= a;
        @(posedge clock);
        rd_req <= 0;
        for (k = 1; k < 30; k++) begin
            enable <= !(k >= 3 && k < 3 + stall);
            @(posedge clock);
            if (rd_valid === 1'b1) break;
        end
        enable <= 1;
        if (k == 30) timeout("rd_valid");
        check("read latency", 16'(k), 16'(9 + stall));
        check("read data", {8'h0, rd_data}, {8'h0, shadow[a]});
    endtask

    // loads n bytes, writes the page, expects done or error, then reads back
    task automatic page_write(input logic [6:0] pg, input int n, input logic [9:0] plen);
        logic [5:0] bo [64];
        logic [7:0] bd [64];
        logic       ok;
        int         k;
        ok = (plen < 10'd150);
        prog_len <= plen;
        for (int i = 0; i < n; i++) begin
            bo[i] = 6'($urandom);
            bd[i] = 8'($urandom);
            push(bo[i], bd[i]);
        end
        load_valid <= 0;
        @(posedge clock);
        @(posedge clock);
        check("load_ready after load", load_ready, n < 64);
        wr_req <= 1;
        wr_page <= pg;
        @(posedge clock);
        wr_req <= 0;
        for (k = 0; k < 3000; k++) begin
            @(posedge clock);
            if (wr_done === 1'b1 || wr_error === 1'b1) break;
        end
        if (k == 3000) timeout("wr_done");
        check("write done", wr_done, ok);
        check("write error", wr_error, !ok);
        check("device idle at done", dev_busy, !ok);
        if (!ok) repeat (500) @(posedge clock);
        for (int i = 0; i < n; i++) shadow[{pg, bo[i]}] = bd[i];
        for (int i = 0; i < n; i++) rd({pg, bo[i]});
    endtask

    // ==========================================================
    // main sequence
    initial begin
        arst_n = 0;
        enable = 1;
        load_valid = 0;
        load_offset = 6'h00;
        load_data = 8'h00;
        wr_req = 0;
        wr_page = 7'h00;
        rd_req = 0;
        rd_addr = 13'h0000;
        prog_len = 10'h00a;
        void'($urandom(80));
        for (int a = 0; a < 8192; a++) shadow[a] = 8'(a) ^ 8'(a >> 5);
        repeat (8) @(posedge clock);
        check("ce_n in reset", mem_ce_n, 1'b1);
        check("dq_oe in reset", mem_dq_oe, 1'b0);
        check("busy in reset", busy, 1'b0);
        arst_n <= 1;
        repeat (3) @(posedge clock);
        check("load_ready after reset", load_ready, 1'b1);
        rd(13'h0000);
        rd(13'h1fff);
        rd(13'h0abc, 4);
        repeat (4) rd(13'($urandom));
        page_write(7'h00, 1, 10'h005);
        page_write(7'h7f, 64, 10'h00a);
        page_write(7'h7f, 2, 10'h078);
        for (int i = 0; i < 4; i++) begin
            page_write(7'($urandom), 1 + $urandom % 64, 10'(5 + $urandom % 100));
        end
        page_write(7'($urandom), 3, 10'h190);
        page_write(7'h2a, 5, 10'h010);
        // a request with nothing loaded is refused
        wr_req <= 1;
        @(posedge clock);
        wr_req <= 0;
        repeat (2) @(posedge clock);
        check("busy on empty write", busy, 1'b0);
        check("device rule breaches", viol, 16'h0);
        end_sim();
    end
endmodule
`default_nettype wire
